// File: design/uhig_enable_bank.sv
/*
 * Enable storage shared by the set-only and clear-only registers.
 * Assumes set and clear masks are one-cycle strobes from the bus slave.
 */
`timescale 1ns/1ps
`default_nettype none
module uhig_enable_bank
   import uhig_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // write strobes
   input wire logic [31:0] set_bits,
   input wire logic [31:0] clear_bits,
   // enable image
   output var logic [31:0] en_bits
);

   uhig_enable_state_type st;
   uhig_enable_state_type next_st;

   always_comb begin
      next_st = st;
      next_st.master = (st.master | set_bits[MIE_BIT]) &
                       ~clear_bits[MIE_BIT];
      next_st.event_en = (st.event_en | set_bits[EVT_W-1:0]) &
                         ~clear_bits[EVT_W-1:0] & EVT_IMPL_MASK;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st <= '{master: 1'b0, event_en: EVT_RESET};
      end else begin
         st <= next_st;
      end
   end

   // reserved positions read zero
   assign en_bits = {st.master, 24'h00_0000, st.event_en} & EN_IMPL_MASK;

endmodule // uhig_enable_bank
`default_nettype wire

// File: design/uhig_flag_bank.sv
/*
 * Sticky event flags: hardware sets, software clears by writing ones.
 * Assumes events are single-cycle or level pulses from core_clk logic.
 */
`timescale 1ns/1ps
`default_nettype none
module uhig_flag_bank
   import uhig_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // event sources and clear strobe
   input wire logic [6:0] event_bits,
   input wire logic [6:0] clear_bits,
   // flag image
   output var logic [6:0] flags
);

   uhig_flag_state_type st;
   uhig_flag_state_type next_st;

   // set wins over a clear in the same cycle
   always_comb begin
      next_st = st;
      next_st.flags = ((st.flags & ~clear_bits) | event_bits) &
                      EVT_IMPL_MASK;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st <= '{flags: EVT_RESET};
      end else begin
         st <= next_st;
      end
   end

   assign flags = st.flags;

endmodule // uhig_flag_bank
`default_nettype wire

// File: design/uhig_pkg.sv
/*
 * Shared constants and types of the host interrupt enable gate: register
 * indices, bit positions, masks, reset values, bus states, state records.
 * Assumes a single core clock and a synchronous active-high reset.
 */
package uhig_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned EVT_W = 7;
   localparam int unsigned LANES = 4;
   localparam int unsigned MIE_BIT = 31;

   // ------------------------------------------------------------
   // register indices and byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_IDX = 8'h03;
   localparam logic [7:0] SET_IDX = 8'h04;
   localparam logic [7:0] CLR_IDX = 8'h05;
   localparam logic [7:0] STATUS_ADDR = 8'(STATUS_IDX * 4);
   localparam logic [7:0] SET_ADDR = 8'(SET_IDX * 4);
   localparam logic [7:0] CLR_ADDR = 8'(CLR_IDX * 4);

   // ------------------------------------------------------------
   // event bit positions, masks, reset values
   // ------------------------------------------------------------
   localparam int unsigned EVT_ROOT = 6;
   localparam int unsigned EVT_WRAP = 5;
   localparam int unsigned EVT_FATAL = 4;
   localparam int unsigned EVT_RESUME = 3;
   localparam int unsigned EVT_FBEGIN = 2;
   localparam int unsigned EVT_RSVD = 1;
   localparam int unsigned EVT_OVERRUN = 0;
   localparam logic [31:0] EN_IMPL_MASK = 32'h8000_007d;
   localparam logic [6:0] EVT_IMPL_MASK = 7'h7d;
   localparam logic [6:0] EVT_RESET = 7'h00;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   localparam logic [31:0] RD_RESET = 32'h0000_0000;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic root_port_change_event;
      logic frame_count_wrap_event;
      logic fatal_system_error_event;
      logic resume_detect_event;
      logic frame_begin_event;
      logic reserved_event;
      logic sched_overrun_event;
   } uhig_event_type;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ANSWER = 2'b10
   } uhig_bus_type;

   typedef struct packed {
      uhig_bus_type bus;
      logic waitrequest;
      logic [31:0] readdata;
      logic irq;
   } uhig_top_state_type;

   typedef struct packed {
      logic master;
      logic [6:0] event_en;
   } uhig_enable_state_type;

   typedef struct packed {
      logic [6:0] flags;
   } uhig_flag_state_type;

endpackage

// File: design/uhig_top.sv
/*
 * Interrupt enable gate of the host controller: event flags, set-only and
 * clear-only enable registers over an Avalon-MM slave, one level irq.
 * Assumes the bus master and the event sources run on core_clk.
 */
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uhig_top
   import uhig_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output var logic [31:0] avs_readdata,
   output var logic avs_waitrequest,
   // host controller events
   input wire uhig_event_type host_events,
   // interrupt to the microprocessor
   output var logic irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   uhig_top_state_type st;
   uhig_top_state_type next_st;

   logic [31:0] be_mask;
   logic [31:0] wr_bits;
   logic [31:0] en_bits;
   logic [31:0] set_bits;
   logic [31:0] clear_bits;
   logic [31:0] rd_value;
   logic [6:0] flags;
   logic [6:0] event_bits;
   logic [6:0] flag_clear;
   logic [6:0] gated;
   logic acc_wr;
   logic acc_rd;
   logic hit_stat;
   logic hit_set;
   logic hit_clr;
   logic master;
   logic irq_term;

   // ------------------------------------------------------------
   // byte lanes
   // ------------------------------------------------------------
   genvar lane;
   generate
      for (lane = 0; lane < LANES; lane++) begin : g_lane
         assign be_mask[lane*8 +: 8] = {8{avs_byteenable[lane]}};
      end
   endgenerate

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   // the access takes effect only in the answer cycle
   assign acc_wr = (st.bus == BUS_ANSWER) && avs_write;
   assign acc_rd = (st.bus == BUS_ANSWER) && avs_read;
   assign hit_stat = {avs_address[7:2], 2'b00} == STATUS_ADDR;
   assign hit_set = {avs_address[7:2], 2'b00} == SET_ADDR;
   assign hit_clr = {avs_address[7:2], 2'b00} == CLR_ADDR;
   assign wr_bits = avs_writedata & be_mask & EN_IMPL_MASK;

   assign set_bits = (acc_wr && hit_set) ? wr_bits : '0;
   assign clear_bits = (acc_wr && hit_clr) ? wr_bits : '0;
   assign flag_clear = (acc_wr && hit_stat) ?
                       wr_bits[EVT_W-1:0] : EVT_RESET;
   assign event_bits = host_events & EVT_IMPL_MASK;
   assign master = en_bits[MIE_BIT];

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   uhig_enable_bank u_enable (
      .core_clk(core_clk),
      .srst(srst),
      .set_bits(set_bits),
      .clear_bits(clear_bits),
      .en_bits(en_bits)
   );

   uhig_flag_bank u_flags (
      .core_clk(core_clk),
      .srst(srst),
      .event_bits(event_bits),
      .clear_bits(flag_clear),
      .flags(flags)
   );

   // ------------------------------------------------------------
   // interrupt gating
   // ------------------------------------------------------------
   assign gated[EVT_ROOT] = flags[EVT_ROOT] & en_bits[EVT_ROOT];
   assign gated[EVT_WRAP] = flags[EVT_WRAP] & en_bits[EVT_WRAP];
   assign gated[EVT_FATAL] = flags[EVT_FATAL] & en_bits[EVT_FATAL];
   assign gated[EVT_RESUME] = flags[EVT_RESUME] &
                              en_bits[EVT_RESUME];
   assign gated[EVT_FBEGIN] = flags[EVT_FBEGIN] &
                              en_bits[EVT_FBEGIN];
   assign gated[EVT_RSVD] = 1'b0;
   assign gated[EVT_OVERRUN] = flags[EVT_OVERRUN] &
                               en_bits[EVT_OVERRUN];
   assign irq_term = master && (|gated);

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      rd_value = RD_UNMAPPED;
      if (hit_stat) begin
         rd_value = {25'h000_0000, flags};
      end else if (hit_set || hit_clr) begin
         rd_value = en_bits;
      end
   end

   // ------------------------------------------------------------
   // bus answer and irq register
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.irq = irq_term;
      unique case (st.bus)
         BUS_IDLE: begin
            if (avs_read || avs_write) begin
               next_st.bus = BUS_ANSWER;
               next_st.waitrequest = 1'b0;
               next_st.readdata = avs_read ? rd_value : RD_RESET;
            end
         end
         BUS_ANSWER: begin
            next_st.bus = BUS_IDLE;
            next_st.waitrequest = 1'b1;
         end
         default: begin
            next_st.bus = BUS_IDLE;
            next_st.waitrequest = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st <= '{bus: BUS_IDLE, waitrequest: 1'b1,
                 readdata: RD_RESET, irq: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata = st.readdata;
   assign avs_waitrequest = st.waitrequest;
   assign irq = st.irq;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   sequence set_write_s;
      acc_wr && hit_set;
   endsequence

   sequence clr_write_s;
      acc_wr && hit_clr;
   endsequence

   sequence stat_write_s;
      acc_wr && hit_stat;
   endsequence

   sequence request_s;
      (avs_read || avs_write) && (st.bus == BUS_IDLE);
   endsequence

   sequence stat_read_s;
      acc_rd && hit_stat;
   endsequence

   sequence stray_s;
      (acc_rd || acc_wr) && !hit_stat && !hit_set && !hit_clr;
   endsequence

   irq_follow_a:
   assert property (irq == $past(irq_term))
      else $error("irq does not follow gated flags");

   en_set_a:
   assert property (set_write_s |=>
      ((en_bits & $past(wr_bits)) == $past(wr_bits)) &&
      (((en_bits ^ $past(en_bits)) & ~$past(wr_bits)) == 32'h0000_0000))
      else $error("enable set write wrong");

   en_read_a:
   assert property ((acc_rd && hit_set) |-> avs_readdata == en_bits)
      else $error("enable read returns wrong value");

   en_clear_a:
   assert property (clr_write_s |=>
      ((en_bits & $past(wr_bits)) == 32'h0000_0000) &&
      (((en_bits ^ $past(en_bits)) & ~$past(wr_bits)) == 32'h0000_0000))
      else $error("disable write wrong");

   dis_read_a:
   assert property ((acc_rd && hit_clr) |-> avs_readdata == en_bits)
      else $error("disable read differs from enable");

   mie_set_a:
   assert property ((set_write_s ##0 wr_bits[MIE_BIT]) |=> master)
      else $error("master enable not set");

   mie_zero_a:
   assert property ((acc_wr && !hit_clr && !wr_bits[MIE_BIT]) |=>
      master == $past(master))
      else $error("master enable moved on zero write");

   mie_clear_a:
   assert property ((clr_write_s ##0 wr_bits[MIE_BIT]) |=>
      !master ##1 !irq)
      else $error("master clear did not silence irq");

   gate_root_a:
   assert property ((flags[EVT_ROOT] && !en_bits[EVT_ROOT] &&
      (gated & ~7'h40) == 7'h00) |=> !irq)
      else $error("disabled root event raised irq");

   gate_fatal_a:
   assert property ((master && flags[EVT_FATAL] && en_bits[EVT_FATAL])
      |=> irq)
      else $error("enabled fatal event missed");

   rsvd_bit_a:
   assert property (flags[EVT_RSVD] == 1'b0 && en_bits[EVT_RSVD] == 1'b0)
      else $error("reserved bit set");

   flag_set_a:
   assert property ((|event_bits) |=>
      (flags & $past(event_bits)) == $past(event_bits))
      else $error("event did not set flag");

   flag_hold_a:
   assert property (!(acc_wr && hit_stat) |=>
      ($past(flags) & ~flags) == 7'h00)
      else $error("flag dropped without clear");

   flag_clear_a:
   assert property (stat_write_s |=>
      (flags & $past(flag_clear) & ~$past(event_bits)) == 7'h00)
      else $error("status write did not clear flag");

   rsvd_read_a:
   assert property ((en_bits & ~EN_IMPL_MASK) == 32'h0000_0000)
      else $error("reserved enable bit reads one");

   irq_drop_a:
   assert property (!irq_term |=> !irq)
      else $error("irq stayed high without cause");

   bus_answer_a:
   assert property (request_s |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");

   // a flag may rise between capture and answer, never fall
   stat_read_a:
   assert property (stat_read_s |->
      (avs_readdata & ~{25'h000_0000, flags}) == 32'h0000_0000)
      else $error("status read returns wrong value");

   stray_read_a:
   assert property ((stray_s ##0 avs_read) |-> avs_readdata == RD_UNMAPPED)
      else $error("unmapped read not zero");

   stray_write_a:
   assert property ((stray_s ##0 avs_write) |=>
      en_bits == $past(en_bits))
      else $error("unmapped write changed enables");

   wr_answer_a:
   assert property (acc_wr |-> avs_readdata == RD_RESET)
      else $error("write answer carries data");

   gate_root_on_a:
   assert property ((master && flags[EVT_ROOT] && en_bits[EVT_ROOT])
      |=> irq)
      else $error("enabled root event missed");

   gate_wrap_a:
   assert property ((master && flags[EVT_WRAP] && en_bits[EVT_WRAP])
      |=> irq)
      else $error("enabled wrap event missed");

   gate_resume_a:
   assert property ((flags[EVT_RESUME] && !en_bits[EVT_RESUME] &&
      (gated & ~7'h08) == 7'h00) |=> !irq)
      else $error("disabled resume event raised irq");

   gate_fbegin_a:
   assert property ((master && flags[EVT_FBEGIN] && en_bits[EVT_FBEGIN])
      |=> irq)
      else $error("enabled frame begin event missed");

   gate_overrun_a:
   assert property ((master && flags[EVT_OVERRUN] && en_bits[EVT_OVERRUN])
      |=> irq)
      else $error("enabled overrun event missed");

   irq_master_a:
   assert property (irq |-> $past(master))
      else $error("irq without master enable");

   master_off_a:
   assert property (!master |=> !irq)
      else $error("irq high with master off");

   wait_idle_a:
   assert property ((st.bus == BUS_IDLE) |-> avs_waitrequest)
      else $error("waitrequest low while idle");

endmodule // uhig_top
`default_nettype wire

// File: test/tb.sv
/*
 * Self-checking bench of the interrupt enable gate.
 * Assumes the host model drives the bus and the bench drives events.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
   import uhig_pkg::*;
();
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   uhig_event_type ev = '0;
   logic [7:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, irq;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   int n_mismatch = 0;
   int compares = 0;

   always #50 core_clk = ~core_clk;

   uhig_top u_uhig_top (
      .core_clk(core_clk),
      .srst(srst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .host_events(ev),
      .irq(irq)
   );

   uhig_host_model u_uhig_host_model (
      .core_clk(core_clk),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );

   // ----------------------------------------------------------
   // checking and bus helpers
   // ----------------------------------------------------------
   task automatic close_out;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      cmp32({31'h0, got}, {31'h0, exp});
   endtask

   task automatic wr(input logic [7:0] code, input logic [31:0] d,
      input logic [3:0] be);
      logic ok;
      u_uhig_host_model.command(code, d, be, rd, ok);
      cmp1(ok, 1'b1);
   endtask

   task automatic rchk(input logic [7:0] code, input logic [31:0] exp);
      wr(code, 32'h0, 4'hf);
      cmp32(rd, exp);
   endtask

   // irq settles two cycles after its cause
   task automatic irq_is(input logic exp);
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      cmp1(irq, exp);
      @(posedge core_clk);
   endtask

   task automatic pulse(input int b);
      ev <= 7'(7'h01 << b);
      @(posedge core_clk);
      ev <= '0;
      @(posedge core_clk);
   endtask

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_regs;
      rchk(8'h04, 32'h0);
      rchk(8'h05, 32'h0);
      wr(8'h84, 32'hffffffff, 4'h1);
      rchk(8'h04, 32'h0000007d);
      wr(8'h84, 32'hffffffff, 4'hf);
      rchk(8'h04, 32'h8000007d);
      wr(8'h84, 32'h0, 4'hf);
      rchk(8'h05, 32'h8000007d);
      wr(8'h85, 32'h00000014, 4'hf);
      rchk(8'h04, 32'h80000069);
      wr(8'h85, 32'h0, 4'hf);
      rchk(8'h05, 32'h80000069);
      wr(8'h85, 32'h80000000, 4'hf);
      rchk(8'h04, 32'h00000069);
      wr(8'h90, 32'hffffffff, 4'hf);
      rchk(8'h10, 32'h0);
      rchk(8'h04, 32'h00000069);
      wr(8'h85, 32'hffffffff, 4'hf);
      rchk(8'h04, 32'h0);
   endtask

   task automatic t_gate;
      int j;
      for (int i = 0; i < 7; i++) begin
         j = (i + 1) % 7;
         wr(8'h85, 32'hffffffff, 4'hf);
         wr(8'h83, 32'h7f, 4'hf);
         wr(8'h84, 32'h80000000 | (32'h1 << i), 4'hf);
         pulse(j);
         irq_is(1'b0);
         pulse(i);
         irq_is(i != 1);
         rchk(8'h03, ((32'h1 << i) | (32'h1 << j)) & 32'h7d);
         wr(8'h85, 32'h80000000, 4'hf);
         irq_is(1'b0);
         wr(8'h84, 32'h80000000, 4'hf);
         wr(8'h83, 32'h0, 4'hf);
         irq_is(i != 1);
         wr(8'h83, 32'h1 << i, 4'hf);
         irq_is(1'b0);
         rchk(8'h03, (32'h1 << j) & 32'h7d);
      end
   endtask

   // reset in mid-run drops irq, enables and flags
   task automatic t_reset;
      wr(8'h84, 32'h80000010, 4'hf);
      pulse(EVT_FATAL);
      irq_is(1'b1);
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      @(negedge core_clk);
      cmp1(irq, 1'b0);
      cmp1(avs_waitrequest, 1'b1);
      @(posedge core_clk);
      rchk(8'h04, 32'h0);
      rchk(8'h03, 32'h0);
   endtask

   // ----------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      cmp1(avs_waitrequest, 1'b1);
      cmp1(irq, 1'b0);
      cmp32(avs_readdata, 32'h0);
      @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      t_regs();
      t_gate();
      t_reset();
      close_out();
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      close_out();
   end
endmodule // tb
`default_nettype wire

// File: test/uhig_host_model.sv
/*
 * Host processor model: issues register commands over Avalon-MM.
 * Assumes callers enter its task right after a rising core_clk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module uhig_host_model
   import uhig_pkg::*;
(
   // clock
   input wire logic core_clk,
   // avalon-mm master
   output var logic [7:0] avs_address,
   output var logic avs_read,
   output var logic avs_write,
   output var logic [31:0] avs_writedata,
   output var logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
   end

   // code bit 7 selects write, low bits give the word index
   task automatic command(input logic [7:0] code, input logic [31:0] wdata,
      input logic [3:0] be, output logic [31:0] rdata, output logic ok);
      int n;
      n = 0;
      avs_address <= {code[5:0], 2'b00};
      avs_write <= code[7];
      avs_read <= ~code[7];
      avs_writedata <= wdata;
      avs_byteenable <= be;
      @(posedge core_clk);
      // only the bench watchdog ends a wait that never closes
      while (avs_waitrequest !== 1'b0) begin
         n++;
         @(posedge core_clk);
      end
      rdata = avs_readdata;
      // one wait cycle per access
      ok = (n == 1);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // released address and data lines no longer show the last value
      avs_address <= ~{code[5:0], 2'b00};
      avs_writedata <= ~wdata;
      @(posedge core_clk);
   endtask
endmodule // uhig_host_model
`default_nettype wire
